//--- design/sideport_addr_map.sv
// physical address to bank, row, column and byte mask translation
`timescale 1ns/10ps
`default_nettype none

module sideport_addr_map (
    // request address
    input wire logic [sideport_pkg::ADDR_W-1:0] paddr,
    input wire logic byte_only,
    input wire logic pre_flag,
    // geometry selection
    input wire logic is_ddr3,
    input wire logic [sideport_pkg::CODE_W-1:0] size_code,
    input wire logic interleave,
    // result
    output sideport_pkg::loc_s loc,
    output logic geom_ok
);

    logic tiny;
    logic wide;
    logic bank3;
    logic [sideport_pkg::BANK_W-1:0] bank_raw;
    logic [sideport_pkg::BANK_W-1:0] bank_mix;

    // geometry from the size code
    assign tiny = !is_ddr3 && (size_code == sideport_pkg::CODE_DDR2_256M);
    assign wide = is_ddr3 ? (size_code == sideport_pkg::CODE_DDR3_1G)
                          : (size_code == sideport_pkg::CODE_DDR2_1G);
    assign bank3 = is_ddr3 || wide;
    assign geom_ok = is_ddr3
        ? (size_code == sideport_pkg::CODE_DDR3_512M) || wide
        : tiny || wide || (size_code == sideport_pkg::CODE_DDR2_512M);

    // bank bits sit just above the highest mapped address bit
    assign bank_raw = wide ? paddr[27:25]
                    : tiny ? {1'b0, paddr[24:23]}
                    : bank3 ? paddr[26:24]
                    : {1'b0, paddr[25:24]};
    // interleaved mode spreads neighbouring pages over banks
    assign bank_mix = interleave ? bank_raw ^ paddr[17:15] : bank_raw;
    assign loc.bank = bank3 ? bank_mix : {1'b0, bank_mix[1:0]};

    assign loc.row = {wide ? paddr[24] : 1'b0,
                      tiny ? paddr[10] : paddr[23],
                      paddr[14:11],
                      paddr[22:15]};

    assign loc.col = {3'h0,
                      pre_flag,
                      tiny ? 1'b0 : paddr[10],
                      paddr[9:1]};

    // P0 picks the byte lane only
    assign loc.mask = !byte_only ? sideport_pkg::MASK_NONE
                    : paddr[0] ? sideport_pkg::MASK_LOW
                    : sideport_pkg::MASK_HIGH;

endmodule

`default_nettype wire

//--- design/sideport_ddr_addr_mapper.sv
// side-port frame buffer memory controller, one x16 device
//
// What this block does
// - one DDR2 rank on a 16-bit bus
// - exactly one chip select output
// - DDR2 x16 of 256, 512, 1024 Mbit
// - DDR2 codes 4, 10, 11 select geometry
// - DDR3 one x16 device, 512 or 1024 Mbit
// - DDR3 codes 9 and 11 select geometry
// - row bits built from P10 to P23
// - column P1 to P10, A10 precharge flag
// - largest devices add P24 on A13
// - up to 800 MT/s, interleaved mode
// - display refresh fetched from this memory
// - timing and options come from configuration
// - only graphics core and display refresh requesters are served
`timescale 1ns/10ps
`default_nettype none

module sideport_ddr_addr_mapper (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // configuration
    input wire logic cfg_is_ddr3,
    input wire logic [sideport_pkg::CODE_W-1:0] cfg_size_code,
    input wire logic cfg_interleave,
    input wire logic cfg_auto_pre,
    input wire logic [sideport_pkg::TIME_W-1:0] cfg_t_rcd,
    input wire logic [sideport_pkg::TIME_W-1:0] cfg_t_cl,
    input wire logic [sideport_pkg::TIME_W-1:0] cfg_t_rp,
    output logic cfg_bad,
    // request from the graphics side
    input wire logic req_valid,
    input wire sideport_pkg::req_s req,
    output logic req_ready,
    // answer
    output logic resp_valid,
    output logic resp_err,
    output logic [sideport_pkg::DQ_W-1:0] resp_rdata,
    // memory pins
    output logic mem_cs_n,
    output logic mem_ras_n,
    output logic mem_cas_n,
    output logic mem_we_n,
    output logic [sideport_pkg::BANK_W-1:0] mem_ba,
    output logic [sideport_pkg::ROW_W-1:0] mem_a,
    output logic [1:0] mem_dm,
    output logic [sideport_pkg::DQ_W-1:0] mem_dq_o,
    output logic mem_dq_oe_n,
    input wire logic [sideport_pkg::DQ_W-1:0] mem_dq_i
);

    typedef enum logic [2:0] {
        st_idle,
        st_act,
        st_rcd,
        st_rw,
        st_lat,
        st_pch,
        st_rp
    } state_e;

    state_e state_q;
    state_e state_d;

    // latched request
    sideport_pkg::loc_s loc_q;
    sideport_pkg::loc_s loc_w;
    logic write_q;
    logic [sideport_pkg::DQ_W-1:0] wdata_q;
    logic pre_q;
    logic geom_ok;

    // registered pin values
    logic [2:0] cmd_q;
    logic [2:0] cmd_d;
    logic cs_n_q;
    logic [sideport_pkg::BANK_W-1:0] ba_q;
    logic [sideport_pkg::ROW_W-1:0] a_q;
    logic [sideport_pkg::ROW_W-1:0] a_d;
    logic [1:0] dm_q;
    logic [sideport_pkg::DQ_W-1:0] dq_o_q;
    logic dq_oe_n_q;
    logic dq_oe_n_d;

    // read data synchroniser
    logic [sideport_pkg::DQ_W-1:0] dq_s1_q;
    logic [sideport_pkg::DQ_W-1:0] dq_s2_q;

    // answer registers
    logic resp_valid_q;
    logic resp_err_q;
    logic [sideport_pkg::DQ_W-1:0] rdata_q;

    // timer controls
    logic rcd_start;
    logic rcd_done;
    logic lat_start;
    logic lat_done;
    logic rp_start;
    logic rp_done;

    // request qualification
    logic take;
    logic src_ok;
    logic reject;
    logic accept;

    sideport_addr_map u_map (
        .paddr(req.addr),
        .byte_only(req.byte_only),
        .pre_flag(cfg_auto_pre),
        .is_ddr3(cfg_is_ddr3),
        .size_code(cfg_size_code),
        .interleave(cfg_interleave),
        .loc(loc_w),
        .geom_ok(geom_ok)
    );

    // programmed waits between commands
    sideport_timer #(.W(sideport_pkg::TIME_W)) u_rcd (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(rcd_start),
        .count(cfg_t_rcd),
        .done(rcd_done)
    );

    sideport_timer #(.W(sideport_pkg::TIME_W)) u_lat (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(lat_start),
        .count(cfg_t_cl),
        .done(lat_done)
    );

    sideport_timer #(.W(sideport_pkg::TIME_W)) u_rp (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(rp_start),
        .count(cfg_t_rp),
        .done(rp_done)
    );

    // graphics core and display refresh only
    assign src_ok = (req.src == sideport_pkg::src_gfx)
                 || (req.src == sideport_pkg::src_display);
    assign cfg_bad = !geom_ok;
    assign req_ready = (state_q == st_idle);
    assign take = req_valid && req_ready;
    assign reject = take && (!src_ok || !geom_ok);
    assign accept = take && src_ok && geom_ok;

    assign rcd_start = (state_q == st_act);
    assign lat_start = (state_q == st_rw);
    assign rp_start = (state_q == st_pch)
                   || ((state_q == st_lat) && lat_done && pre_q);

    // state sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            st_idle: begin
                if (accept) begin
                    state_d = st_act;
                end
            end
            st_act: begin
                state_d = st_rcd;
            end
            st_rcd: begin
                if (rcd_done) begin
                    state_d = st_rw;
                end
            end
            st_rw: begin
                state_d = st_lat;
            end
            st_lat: begin
                if (lat_done) begin
                    state_d = pre_q ? st_rp : st_pch;
                end
            end
            st_pch: begin
                state_d = st_rp;
            end
            st_rp: begin
                if (rp_done) begin
                    state_d = st_idle;
                end
            end
        endcase
    end

    // command and address for the next pin cycle
    assign cmd_d = (state_q == st_act) ? sideport_pkg::CMD_ACT
                 : (state_q == st_rw) ? (write_q ? sideport_pkg::CMD_WR
                                                 : sideport_pkg::CMD_RD)
                 : (state_q == st_pch) ? sideport_pkg::CMD_PRE
                 : sideport_pkg::CMD_NOP;
    assign a_d = (state_q == st_act) ? loc_q.row
               : (state_q == st_rw) ? loc_q.col
               : '0;
    assign dq_oe_n_d = !(write_q && ((state_q == st_rw) || (state_q == st_lat)));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= st_idle;
        end else begin
            state_q <= state_d;
        end
    end

    // request capture
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            loc_q <= '0;
            write_q <= 1'b0;
            wdata_q <= sideport_pkg::DQ_RST;
            pre_q <= 1'b0;
        end else if (accept) begin
            loc_q <= loc_w;
            write_q <= req.write;
            wdata_q <= req.wdata;
            pre_q <= cfg_auto_pre;
        end
    end

    // single rank, chip select only during commands
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_q <= sideport_pkg::CMD_NOP;
            cs_n_q <= 1'b1;
            ba_q <= '0;
            a_q <= '0;
        end else begin
            cmd_q <= cmd_d;
            cs_n_q <= (cmd_d == sideport_pkg::CMD_NOP);
            ba_q <= loc_q.bank;
            a_q <= a_d;
        end
    end

    // 16-bit data lanes and byte masks
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dm_q <= sideport_pkg::MASK_NONE;
            dq_o_q <= sideport_pkg::DQ_RST;
            dq_oe_n_q <= 1'b1;
        end else begin
            dm_q <= loc_q.mask;
            dq_o_q <= wdata_q;
            dq_oe_n_q <= dq_oe_n_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dq_s1_q <= sideport_pkg::DQ_RST;
            dq_s2_q <= sideport_pkg::DQ_RST;
        end else begin
            dq_s1_q <= mem_dq_i;
            dq_s2_q <= dq_s1_q;
        end
    end

    // answer: error at once, data after the access latency
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            resp_valid_q <= 1'b0;
            resp_err_q <= 1'b0;
            rdata_q <= sideport_pkg::DQ_RST;
        end else begin
            resp_valid_q <= reject || ((state_q == st_lat) && lat_done);
            resp_err_q <= reject;
            if ((state_q == st_lat) && lat_done && !write_q) begin
                rdata_q <= dq_s2_q;
            end
        end
    end

    assign resp_valid = resp_valid_q;
    assign resp_err = resp_err_q;
    assign resp_rdata = rdata_q;
    assign mem_cs_n = cs_n_q;
    assign mem_ras_n = cmd_q[2];
    assign mem_cas_n = cmd_q[1];
    assign mem_we_n = cmd_q[0];
    assign mem_ba = ba_q;
    assign mem_a = a_q;
    assign mem_dm = dm_q;
    assign mem_dq_o = dq_o_q;
    assign mem_dq_oe_n = dq_oe_n_q;

endmodule

`default_nettype wire

//--- design/sideport_pkg.sv
// shared constants and types of the side-port memory controller
package sideport_pkg;

    // widths
    localparam int ADDR_W = 28;
    localparam int DQ_W = 16;
    localparam int BANK_W = 3;
    localparam int ROW_W = 14;
    localparam int COL_W = 14;
    localparam int CODE_W = 4;
    localparam int TIME_W = 4;

    // device size codes
    localparam logic [CODE_W-1:0] CODE_DDR2_256M = 4'h4;
    localparam logic [CODE_W-1:0] CODE_DDR2_512M = 4'hA;
    localparam logic [CODE_W-1:0] CODE_DDR2_1G = 4'hB;
    localparam logic [CODE_W-1:0] CODE_DDR3_512M = 4'h9;
    localparam logic [CODE_W-1:0] CODE_DDR3_1G = 4'hB;

    // highest transfer rate served, in MT/s
    localparam int MAX_RATE_MT = 800;

    // command encodings {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_PRE = 3'h2;

    // reset values and byte mask encodings
    localparam logic [TIME_W-1:0] TIME_RST = 4'h0;
    localparam logic [DQ_W-1:0] DQ_RST = 16'h0000;
    localparam logic [1:0] MASK_NONE = 2'h0;
    localparam logic [1:0] MASK_LOW = 2'h1;
    localparam logic [1:0] MASK_HIGH = 2'h2;

    typedef enum logic [1:0] {
        src_gfx,
        src_display,
        src_other,
        src_spare
    } src_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic byte_only;
        src_e src;
        logic [DQ_W-1:0] wdata;
    } req_s;

    typedef struct packed {
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [1:0] mask;
    } loc_s;

endpackage

//--- design/sideport_timer.sv
// down-counting wait timer loaded from a programmed cycle count
`timescale 1ns/10ps
`default_nettype none

module sideport_timer #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control
    input wire logic start,
    input wire logic [W-1:0] count,
    // status
    output logic done
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    assign cnt_d = start ? count : (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    assign done = (cnt_q == '0) && !start;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

`default_nettype wire

//--- verif/sideport_ddr_addr_mapper_tb_top.sv
// self-checking bench of the side-port controller
`timescale 1ns/10ps
`default_nettype none
module sideport_ddr_addr_mapper_tb_top;
    logic clk = 1'b0, sys_rst = 1'b1, d3 = 1'b0, ap = 1'b1, req_valid = 1'b0, il = 1'b0;
    logic [3:0] code = 4'h4;
    sideport_pkg::req_s req = '0;
    logic cfg_bad, req_ready, resp_valid, resp_err, cs_n, ras_n, cas_n, we_n, oe_n, got_err;
    logic [15:0] rdata, dq_o, dq_i, got_rd, cap_dq;
    logic [2:0] ba, cap_ba;
    logic [13:0] a, cap_row, cap_col;
    logic [1:0] dm, cap_dm;
    logic cap_we;
    int fail_count = 0, total_checks = 0, cycles = 0, act_n = 0, pre_n = 0;
    localparam logic [27:0] PA = 28'h5A3C96D;

    always #2 clk = ~clk;

    sideport_ddr_addr_mapper i_sideport_ddr_addr_mapper (.clk(clk), .sys_rst(sys_rst),
        .cfg_is_ddr3(d3), .cfg_size_code(code), .cfg_interleave(il), .cfg_auto_pre(ap),
        .cfg_t_rcd(4'h1), .cfg_t_cl(4'h6), .cfg_t_rp(4'h1), .cfg_bad(cfg_bad),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
        .resp_err(resp_err), .resp_rdata(rdata), .mem_cs_n(cs_n), .mem_ras_n(ras_n),
        .mem_cas_n(cas_n), .mem_we_n(we_n), .mem_ba(ba), .mem_a(a), .mem_dm(dm),
        .mem_dq_o(dq_o), .mem_dq_oe_n(oe_n), .mem_dq_i(dq_i));
    sdram_model i_sdram_model (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .a(a), .dq(dq_i));

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // pin capture and hang limit
    always @(posedge clk) begin
        cycles++;
        if (!cs_n && !ras_n && cas_n && we_n) begin
            act_n++;
            cap_row = a;
            cap_ba = ba;
        end
        if (!cs_n && ras_n && !cas_n) begin
            cap_col = a;
            cap_dm = dm;
            cap_we = we_n;
        end
        if (!cs_n && !ras_n && cas_n && !we_n)
            pre_n++;
        if (!oe_n)
            cap_dq = dq_o;
        if (cycles == 6000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic set_cfg(input logic t3, input logic [3:0] c, input logic p);
        @(posedge clk);
        d3 <= t3;
        code <= c;
        ap <= p;
        @(posedge clk);
    endtask

    task automatic do_req(input logic [27:0] pa, input logic wr, input logic bo,
                          input sideport_pkg::src_e src);
        int n;
        n = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{addr: pa, write: wr, byte_only: bo, src: src, wdata: 16'hC35A};
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        req_valid <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (resp_valid !== 1'b1 && n < 100);
        got_err = resp_err;
        got_rd = rdata;
        while (req_ready !== 1'b1 && n < 150) begin
            @(negedge clk);
            n++;
        end
        check(n < 150, 1);
    endtask

    task automatic t_geom();
        logic t3s[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        logic [3:0] cs[5] = '{4'h4, 4'hA, 4'hB, 4'h9, 4'hB};
        logic tiny, wide;
        logic [2:0] eb;
        logic [13:0] ec;
        for (int i = 0; i < 5; i++) begin
            set_cfg(t3s[i], cs[i], 1'b1);
            check(cfg_bad, 0);
            do_req(PA, 1'b0, 1'b0, sideport_pkg::src_display);
            tiny = !t3s[i] && cs[i] == 4'h4;
            wide = cs[i] == 4'hB;
            eb = tiny ? {1'b0, PA[24:23]} : wide ? PA[27:25] : t3s[i] ? PA[26:24] : {1'b0, PA[25:24]};
            ec = {3'h0, 1'b1, tiny ? 1'b0 : PA[10], PA[9:1]};
            check(cap_row, {wide & PA[24], tiny ? PA[10] : PA[23], PA[14:11], PA[22:15]});
            check(cap_col, ec);
            check(cap_ba, eb);
            check({got_err, got_rd}, {1'b0, 2'h3, ec});
        end
        $display("test geometry done");
    endtask

    task automatic t_write();
        int p0;
        set_cfg(1'b0, 4'hA, 1'b0);
        p0 = pre_n;
        do_req(PA, 1'b1, 1'b1, sideport_pkg::src_gfx);
        check({cap_we, cap_dm}, {1'b0, sideport_pkg::MASK_LOW});
        check(cap_dq, 16'hC35A);
        check(got_err, 0);
        check(cap_col[10], 0);
        check(pre_n - p0, 1);
        $display("test write done");
    endtask

    // bank bits mixed with P17..P15 when interleaving, P16..P15 with two bank bits
    task automatic t_interleave();
        set_cfg(1'b1, 4'hB, 1'b1);
        il <= 1'b1;
        do_req(PA, 1'b0, 1'b0, sideport_pkg::src_gfx);
        check(cap_ba, PA[27:25] ^ PA[17:15]);
        set_cfg(1'b0, 4'h4, 1'b1);
        do_req(PA, 1'b0, 1'b0, sideport_pkg::src_gfx);
        check(cap_ba, {1'b0, PA[24:23] ^ PA[16:15]});
        @(posedge clk);
        il <= 1'b0;
        $display("test interleave done");
    endtask

    task automatic t_reject();
        int a0;
        set_cfg(1'b1, 4'h9, 1'b1);
        a0 = act_n;
        do_req(PA, 1'b0, 1'b0, sideport_pkg::src_other);
        check(got_err, 1);
        do_req(PA, 1'b1, 1'b0, sideport_pkg::src_spare);
        check(got_err, 1);
        check(act_n, a0);
        set_cfg(1'b1, 4'hA, 1'b1);
        check(cfg_bad, 1);
        set_cfg(1'b0, 4'h5, 1'b1);
        check(cfg_bad, 1);
        do_req(PA, 1'b0, 1'b0, sideport_pkg::src_gfx);
        check(got_err, 1);
        check(act_n, a0);
        $display("test refusal done");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        t_geom();
        t_write();
        t_interleave();
        t_reject();
        close_out();
    end
endmodule

bind sideport_ddr_addr_mapper sideport_chk i_sideport_chk (.clk(clk), .sys_rst(sys_rst),
    .cfg_is_ddr3(cfg_is_ddr3), .cfg_size_code(cfg_size_code), .cfg_auto_pre(cfg_auto_pre),
    .cfg_bad(cfg_bad), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_err(resp_err), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
    .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_a(mem_a), .mem_dq_oe_n(mem_dq_oe_n));
`default_nettype wire

//--- verif/sideport_monitor.sv
// concurrent checks on the side-port controller ports
`timescale 1ns/10ps
`default_nettype none
module sideport_chk (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // configuration
    input wire logic cfg_is_ddr3,
    input wire logic [sideport_pkg::CODE_W-1:0] cfg_size_code,
    input wire logic cfg_auto_pre,
    input wire logic cfg_bad,
    // request and answer
    input wire logic req_valid,
    input wire sideport_pkg::req_s req,
    input wire logic req_ready,
    input wire logic resp_valid,
    input wire logic resp_err,
    // memory pins
    input wire logic mem_cs_n,
    input wire logic mem_ras_n,
    input wire logic mem_cas_n,
    input wire logic mem_we_n,
    input wire logic [sideport_pkg::ROW_W-1:0] mem_a,
    input wire logic mem_dq_oe_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    wire logic take = req_valid && req_ready;
    wire logic foreign = req.src[1];
    wire logic colcmd = !mem_cs_n && mem_ras_n && !mem_cas_n;
    wire logic actcmd = !mem_cs_n && !mem_ras_n && mem_cas_n && mem_we_n;
    wire logic d3_ok = cfg_size_code == 4'h9 || cfg_size_code == 4'hB;
    wire logic d2_ok = cfg_size_code == 4'h4 || cfg_size_code == 4'hA || cfg_size_code == 4'hB;
    wire logic code_ok = cfg_is_ddr3 ? d3_ok : d2_ok;

    a_bad_code: assert property (cfg_bad == !code_ok)
        else $error("size code flag wrong");
    a_foreign_err: assert property (take && foreign |=> resp_valid && resp_err)
        else $error("foreign request not refused");
    a_foreign_quiet: assert property (take && foreign |=> mem_cs_n [*4])
        else $error("foreign request reached memory");
    a_act_follows: assert property (take && !foreign && !cfg_bad |-> ##[2:3] actcmd)
        else $error("activate missing after request");
    a_cmd_cs: assert property (!mem_ras_n || !mem_cas_n |-> !mem_cs_n)
        else $error("command without chip select");
    a_pre_flag: assert property (colcmd |-> mem_a[10] == cfg_auto_pre)
        else $error("precharge flag wrong on column");
    a_col_top: assert property (colcmd |-> mem_a[13:11] == 3'h0)
        else $error("unused column bits set");
    a_wr_drive: assert property (colcmd && !mem_we_n |-> ##[0:1] !mem_dq_oe_n)
        else $error("write data not driven");

    c_foreign: cover property (take && foreign);
    c_write: cover property (colcmd && !mem_we_n);
    c_no_auto: cover property (colcmd && !cfg_auto_pre);
endmodule
`default_nettype wire

//--- verif/sideport_sdram_model.sv
// behavioural x16 memory answering reads on its data pins
`timescale 1ns/10ps
`default_nettype none
module sdram_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // command pins
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [sideport_pkg::ROW_W-1:0] a,
    // data pins
    output logic [sideport_pkg::DQ_W-1:0] dq
);
    logic [3:0] hold_q;
    // read data follows the column, then the bus churns
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_q <= 4'h0;
            dq <= 16'h0000;
        end else if (!cs_n && ras_n && !cas_n && we_n) begin
            hold_q <= 4'hC;
            dq <= {2'h3, a};
        end else if (hold_q != 4'h0) begin
            hold_q <= hold_q - 4'h1;
        end else begin
            dq <= ~dq;
        end
    end
endmodule
`default_nettype wire
